// [verilog/tcoi_pkg.sv]
// package for the tx checksum offload inserter: offsets, fields, reset values, types
// assumes a 32-bit word stream from the tx fifo, byte 0 of the frame in bits 7:0
package tcoi_pkg;

	// buffer geometry: two command words plus up to 1038 words (4152 bytes) of frame
	localparam int MEM_DEPTH = 1040;
	localparam int ADDR_W = 11;
	localparam logic [10:0] MEM_LIMIT = 11'h0410;
	localparam logic [10:0] FRAME_BASE = 11'h0002;
	localparam logic [12:0] CMD_BYTES = 13'h0008;

	// command word flags
	localparam int CMDA_FIRST_SEG_BIT = 13;
	localparam int CMDB_CSUM_REQ_BIT = 14;

	// checksum prefix word fields
	localparam int INS_MSB = 27;
	localparam int INS_LSB = 16;
	localparam int START_MSB = 11;
	localparam int START_LSB = 0;

	// register word indices, byte offsets, bits and reset value on the avalon slave
	localparam logic [1:0] REG_CTRL = 2'h0;
	localparam logic [1:0] REG_STAT = 2'h1;
	localparam logic [1:0] REG_COUNT = 2'h2;
	localparam logic [1:0] REG_CSUM = 2'h3;
	localparam logic [3:0] REG_CTRL_OFS = 4'h0;
	localparam logic [3:0] REG_STAT_OFS = 4'h4;
	localparam logic [3:0] REG_COUNT_OFS = 4'h8;
	localparam logic [3:0] REG_CSUM_OFS = 4'hC;
	localparam int CTRL_EN_BIT = 0;
	localparam int CTRL_SEL_BIT = 1;
	localparam int STAT_BUSY_BIT = 0;
	localparam int STAT_OVF_BIT = 1;
	localparam logic [31:0] REG_RESET = 32'h0000_0000;

	typedef struct packed
	{
		logic [31:0] data;
		logic last;
		logic [1:0] bytes;
	} tcoi_word_t;

	typedef enum logic [2:0]
	{
		S_RECV = 3'b000,
		S_FOLD = 3'b001,
		S_INS_LO = 3'b010,
		S_INS_HI = 3'b011,
		S_RD = 3'b100,
		S_LOAD = 3'b101,
		S_HOLD = 3'b110
	} tcoi_state_t;

endpackage : tcoi_pkg

// [verilog/tcoi_buf_mem.sv]
// frame buffer: one write port with byte enables, one registered read port
// assumes a single clock and no reset on the storage itself
`timescale 1ns/10ps
module tcoi_buf_mem
(
	input wire logic i_mclk,
	input wire logic i_we,
	input wire logic [3:0] i_be,
	input wire logic [tcoi_pkg::ADDR_W-1:0] i_waddr,
	input wire logic [31:0] i_wdata,
	input wire logic [tcoi_pkg::ADDR_W-1:0] i_raddr,
	output logic [31:0] o_rdata
);

	logic [31:0] mem [tcoi_pkg::MEM_DEPTH];

	for (genvar k = 0; k < 4; k++)
	begin : g_lane
		always_ff @(posedge i_mclk)
		begin
			if (i_we && i_be[k])
				mem[i_waddr][8*k +: 8] <= i_wdata[8*k +: 8];
		end
	end

	always_ff @(posedge i_mclk)
	begin
		o_rdata <= mem[i_raddr];
	end

endmodule : tcoi_buf_mem

// [verilog/tcoi_inserter.sv]
// tx checksum offload inserter between the tx fifo and the mac
// assumes each input packet opens with command word a and b; prefix follows when checksummed
`timescale 1ns/10ps
// Operation
// - prefix bits 27:16 give the byte offset where the checksum is written.
// - prefix bits 11:0 give the byte offset where summing begins.
// - prefix word is dropped when offloading; host still counts it in length.
// - receive-style 16-bit sum from the start offset; one's complement inserted.
// - a zero checksum is inserted as zero, never replaced by all ones.
// - checksum only when request bit, first-segment flag and enable are all set.
// - request bit clear means the packet passes unmodified.
// - 16-bit words with carries added back; odd last byte padded with zero.
// - summing runs from start offset to the final byte of the packet.
module tcoi_inserter
(
	input wire logic i_mclk,
	input wire logic i_rst_n,
	input wire logic [3:0] i_avs_address,
	input wire logic i_avs_read,
	input wire logic i_avs_write,
	input wire logic [31:0] i_avs_writedata,
	input wire logic [3:0] i_avs_byteenable,
	output logic [31:0] o_avs_readdata,
	output logic o_avs_waitrequest,
	input wire tcoi_pkg::tcoi_word_t i_tx,
	input wire logic i_tx_valid,
	output logic o_tx_ready,
	output tcoi_pkg::tcoi_word_t o_mac,
	output logic o_mac_valid,
	input wire logic i_mac_ready
);

	tcoi_pkg::tcoi_state_t state;
	logic tx_offload_enable;
	logic tx_offload_select;
	logic ovf_flag;
	logic [31:0] csum_count;
	logic [15:0] csum_last;
	logic [1:0] hdr_cnt;
	logic first_segment_flag;
	logic do_csum;
	logic drop_pkt;
	logic [11:0] checksum_start_offset;
	logic [11:0] checksum_insert_offset;
	logic [10:0] fcnt;
	logic [31:0] acc;
	logic [10:0] last_addr;
	logic [1:0] last_bytes;
	logic [10:0] rd_addr;
	logic [31:0] rd_data;

	logic take;
	logic is_frame;
	logic [2:0] nb;
	logic [12:0] base;
	logic [31:0] lane_term [4];
	logic [31:0] word_sum;
	logic [10:0] frame_waddr;
	logic [15:0] csum_val;
	logic [12:0] ins_lo_b;
	logic [12:0] ins_hi_b;
	logic ins_lo_is_low;
	logic mem_we;
	logic [3:0] mem_be;
	logic [10:0] mem_waddr;
	logic [31:0] mem_wdata;
	logic bus_req;
	logic bus_ack;
	logic [1:0] reg_idx;
	logic mapped;
	logic wr_fire;

	assign take = i_tx_valid && o_tx_ready;
	assign is_frame = (hdr_cnt == 2'd3);
	assign nb = (i_tx.last && i_tx.bytes != 2'd0) ? {1'b0, i_tx.bytes} : 3'd4;
	assign base = {fcnt, 2'b00};
	assign frame_waddr = tcoi_pkg::FRAME_BASE + fcnt;
	assign csum_val = ~acc[15:0];

	// per-byte contribution; the pair position is counted from the start offset
	for (genvar k = 0; k < 4; k++)
	begin : g_lane
		logic [12:0] idx;
		logic [7:0] b;
		assign idx = base + 13'(k);
		assign b = i_tx.data[8*k +: 8];
		always_comb
		begin
			lane_term[k] = 32'h0000_0000;
			if (do_csum && is_frame && (3'(k) < nb) && (idx >= {1'b0, checksum_start_offset}))
				lane_term[k] = (idx[0] ^ checksum_start_offset[0]) ? {16'h0000, b, 8'h00} : {24'h00_0000, b};
		end
	end

	assign word_sum = lane_term[0] + lane_term[1] + lane_term[2] + lane_term[3];

	// insertion byte addresses inside the buffer, past the two command words
	assign ins_lo_b = {1'b0, checksum_insert_offset} + tcoi_pkg::CMD_BYTES;
	assign ins_hi_b = ins_lo_b + 13'h0001;
	assign ins_lo_is_low = ~(checksum_insert_offset[0] ^ checksum_start_offset[0]);

	always_comb
	begin
		mem_we = 1'b0;
		mem_be = 4'h0;
		mem_waddr = frame_waddr;
		mem_wdata = i_tx.data;
		unique case (state)
			tcoi_pkg::S_RECV:
			begin
				if (take && hdr_cnt != 2'd2 && !(is_frame && frame_waddr >= tcoi_pkg::MEM_LIMIT))
				begin
					mem_we = 1'b1;
					mem_be = 4'hF;
					mem_waddr = is_frame ? frame_waddr : {9'h000, hdr_cnt};
				end
			end
			tcoi_pkg::S_INS_LO:
			begin
				mem_we = 1'b1;
				mem_be = 4'h1 << ins_lo_b[1:0];
				mem_waddr = ins_lo_b[12:2];
				mem_wdata = {4{ins_lo_is_low ? csum_val[7:0] : csum_val[15:8]}};
			end
			tcoi_pkg::S_INS_HI:
			begin
				mem_we = 1'b1;
				mem_be = 4'h1 << ins_hi_b[1:0];
				mem_waddr = ins_hi_b[12:2];
				mem_wdata = {4{ins_lo_is_low ? csum_val[15:8] : csum_val[7:0]}};
			end
			default:
			begin
				mem_we = 1'b0;
			end
		endcase
	end

	tcoi_buf_mem u_mem
	(
		.i_mclk(i_mclk),
		.i_we(mem_we),
		.i_be(mem_be),
		.i_waddr(mem_waddr),
		.i_wdata(mem_wdata),
		.i_raddr(rd_addr),
		.o_rdata(rd_data)
	);

	// packet intake: command words, optional prefix, frame words
	always_ff @(posedge i_mclk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			hdr_cnt <= 2'd0;
			first_segment_flag <= 1'b0;
			do_csum <= 1'b0;
			drop_pkt <= 1'b0;
			checksum_start_offset <= 12'h000;
			checksum_insert_offset <= 12'h000;
			fcnt <= 11'h000;
			acc <= 32'h0000_0000;
			last_addr <= 11'h000;
			last_bytes <= 2'd0;
		end
		else if (state == tcoi_pkg::S_RECV && take)
		begin
			unique case (hdr_cnt)
				2'd0:
				begin
					first_segment_flag <= i_tx.data[tcoi_pkg::CMDA_FIRST_SEG_BIT];
					drop_pkt <= 1'b0;
					acc <= 32'h0000_0000;
					fcnt <= 11'h000;
					hdr_cnt <= 2'd1;
				end
				2'd1:
				begin
					do_csum <= i_tx.data[tcoi_pkg::CMDB_CSUM_REQ_BIT] && first_segment_flag && tx_offload_enable;
					hdr_cnt <= (i_tx.data[tcoi_pkg::CMDB_CSUM_REQ_BIT] && first_segment_flag && tx_offload_enable) ? 2'd2 : 2'd3;
				end
				2'd2:
				begin
					checksum_insert_offset <= i_tx.data[tcoi_pkg::INS_MSB:tcoi_pkg::INS_LSB];
					checksum_start_offset <= i_tx.data[tcoi_pkg::START_MSB:tcoi_pkg::START_LSB];
					hdr_cnt <= 2'd3;
				end
				default:
				begin
					acc <= acc + word_sum;
					if (frame_waddr >= tcoi_pkg::MEM_LIMIT)
						drop_pkt <= 1'b1;
					else
						fcnt <= fcnt + 11'h001;
				end
			endcase
			if (i_tx.last)
			begin
				hdr_cnt <= 2'd0;
				last_bytes <= i_tx.bytes;
				last_addr <= is_frame ? frame_waddr : {9'h000, hdr_cnt};
			end
		end
		else if (state == tcoi_pkg::S_FOLD)
		begin
			acc <= {16'h0000, acc[15:0]} + {16'h0000, acc[31:16]};
		end
	end

	// sequencing: take whole packet, fold, insert, then play out
	always_ff @(posedge i_mclk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			state <= tcoi_pkg::S_RECV;
			o_tx_ready <= 1'b0;
			rd_addr <= 11'h000;
			o_mac <= '0;
			o_mac_valid <= 1'b0;
		end
		else
		begin
			unique case (state)
				tcoi_pkg::S_RECV:
				begin
					o_tx_ready <= 1'b1;
					if (take && i_tx.last)
					begin
						o_tx_ready <= 1'b0;
						rd_addr <= 11'h000;
						// a packet that outgrew the buffer is discarded whole
						if (drop_pkt || (is_frame && frame_waddr >= tcoi_pkg::MEM_LIMIT))
							state <= tcoi_pkg::S_RECV;
						else if (do_csum && hdr_cnt != 2'd2)
							state <= tcoi_pkg::S_FOLD;
						else
							state <= tcoi_pkg::S_RD;
					end
				end
				tcoi_pkg::S_FOLD:
				begin
					if (acc[31:16] == 16'h0000)
						state <= tcoi_pkg::S_INS_LO;
				end
				tcoi_pkg::S_INS_LO:
				begin
					state <= tcoi_pkg::S_INS_HI;
				end
				tcoi_pkg::S_INS_HI:
				begin
					state <= tcoi_pkg::S_RD;
				end
				tcoi_pkg::S_RD:
				begin
					state <= tcoi_pkg::S_LOAD;
				end
				tcoi_pkg::S_LOAD:
				begin
					o_mac.data <= rd_data;
					o_mac.last <= (rd_addr == last_addr);
					o_mac.bytes <= (rd_addr == last_addr) ? last_bytes : 2'd0;
					o_mac_valid <= 1'b1;
					state <= tcoi_pkg::S_HOLD;
				end
				tcoi_pkg::S_HOLD:
				begin
					if (i_mac_ready)
					begin
						o_mac_valid <= 1'b0;
						rd_addr <= rd_addr + 11'h001;
						state <= o_mac.last ? tcoi_pkg::S_RECV : tcoi_pkg::S_RD;
					end
				end
				default:
				begin
					state <= tcoi_pkg::S_RECV;
				end
			endcase
		end
	end

	// avalon slave: waitrequest drops for exactly one cycle per request
	assign bus_req = i_avs_read || i_avs_write;
	assign bus_ack = bus_req && o_avs_waitrequest;
	assign reg_idx = i_avs_address[3:2];
	assign mapped = (i_avs_address[1:0] == 2'b00);
	// writes land on the edge that sees waitrequest low, not on the first sight of the request
	assign wr_fire = i_avs_write && !o_avs_waitrequest;

	always_ff @(posedge i_mclk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			o_avs_waitrequest <= 1'b1;
			o_avs_readdata <= tcoi_pkg::REG_RESET;
		end
		else
		begin
			o_avs_waitrequest <= !bus_ack;
			if (bus_ack && i_avs_read)
			begin
				o_avs_readdata <= tcoi_pkg::REG_RESET;
				if (mapped)
				begin
					unique case (reg_idx)
						tcoi_pkg::REG_CTRL:
						begin
							o_avs_readdata[tcoi_pkg::CTRL_EN_BIT] <= tx_offload_enable;
							o_avs_readdata[tcoi_pkg::CTRL_SEL_BIT] <= tx_offload_select;
						end
						tcoi_pkg::REG_STAT:
						begin
							o_avs_readdata[tcoi_pkg::STAT_BUSY_BIT] <= (state != tcoi_pkg::S_RECV) || (hdr_cnt != 2'd0);
							o_avs_readdata[tcoi_pkg::STAT_OVF_BIT] <= ovf_flag;
						end
						tcoi_pkg::REG_COUNT:
						begin
							o_avs_readdata <= csum_count;
						end
						tcoi_pkg::REG_CSUM:
						begin
							o_avs_readdata <= {16'h0000, csum_last};
						end
					endcase
				end
			end
		end
	end

	// control register; enable and select are only safe to change while idle and flushed
	always_ff @(posedge i_mclk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			tx_offload_enable <= 1'b0;
			tx_offload_select <= 1'b0;
		end
		else if (wr_fire && mapped && reg_idx == tcoi_pkg::REG_CTRL && i_avs_byteenable[0])
		begin
			tx_offload_enable <= i_avs_writedata[tcoi_pkg::CTRL_EN_BIT];
			tx_offload_select <= i_avs_writedata[tcoi_pkg::CTRL_SEL_BIT];
		end
	end

	// status and statistics; overflow set beats a same-cycle write-one clear
	always_ff @(posedge i_mclk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			ovf_flag <= 1'b0;
			csum_count <= tcoi_pkg::REG_RESET;
			csum_last <= 16'h0000;
		end
		else
		begin
			if (state == tcoi_pkg::S_RECV && take && is_frame && frame_waddr >= tcoi_pkg::MEM_LIMIT)
				ovf_flag <= 1'b1;
			else if (wr_fire && mapped && reg_idx == tcoi_pkg::REG_STAT && i_avs_byteenable[0]
				&& i_avs_writedata[tcoi_pkg::STAT_OVF_BIT])
				ovf_flag <= 1'b0;
			if (state == tcoi_pkg::S_INS_HI)
			begin
				csum_count <= csum_count + 32'h0000_0001;
				csum_last <= csum_val;
			end
		end
	end

endmodule : tcoi_inserter

// [tb/tcoi_monitor.sv]
// checker for the inserter ports: bus answer timing and stream hand-off
// assumes it is bound to tcoi_inserter, one clock, async low reset
`timescale 1ns/10ps
module tcoi_monitor
(
	input wire logic i_mclk,
	input wire logic i_rst_n,
	input wire logic [3:0] i_avs_address,
	input wire logic i_avs_read,
	input wire logic i_avs_write,
	input wire logic [31:0] i_avs_writedata,
	input wire logic [3:0] i_avs_byteenable,
	input wire logic [31:0] o_avs_readdata,
	input wire logic o_avs_waitrequest,
	input wire tcoi_pkg::tcoi_word_t i_tx,
	input wire logic i_tx_valid,
	input wire logic o_tx_ready,
	input wire tcoi_pkg::tcoi_word_t o_mac,
	input wire logic o_mac_valid,
	input wire logic i_mac_ready
);
	default clocking cb @(posedge i_mclk);
	endclocking
	default disable iff (!i_rst_n);
	sequence mac_taken_s;
		o_mac_valid && i_mac_ready;
	endsequence
	sequence idle2_s;
		!o_mac_valid ##1 !o_mac_valid;
	endsequence
	bus_answer_a: assert property ((i_avs_read || i_avs_write) && o_avs_waitrequest |=> !o_avs_waitrequest)
		else $error("bus request not answered after one cycle");
	bus_pulse_a: assert property (!o_avs_waitrequest |=> o_avs_waitrequest)
		else $error("waitrequest low longer than one cycle");
	unmapped_zero_a: assert property (i_avs_read && o_avs_waitrequest && i_avs_address[1:0] != 2'h0
		|=> o_avs_readdata == 32'h0000_0000)
		else $error("unmapped read not zero");
	mac_hold_a: assert property (o_mac_valid && !i_mac_ready |=> o_mac_valid && $stable(o_mac))
		else $error("mac word changed before handshake");
	input_stop_a: assert property (i_tx_valid && o_tx_ready && i_tx.last |=> !o_tx_ready)
		else $error("input still open after last word");
	hold_whole_a: assert property (o_mac_valid |-> !o_tx_ready)
		else $error("input open while frame leaves");
	word_gap_a: assert property (mac_taken_s |=> idle2_s)
		else $error("mac valid gap shorter than two cycles");
	tail_bytes_a: assert property (o_mac_valid && !o_mac.last |-> o_mac.bytes == 2'h0)
		else $error("byte count on a middle word");
endmodule : tcoi_monitor

// [tb/tcoi_host_model.sv]
// host side model: streams queued words into the inserter input
// assumes the bench fills q, then calls run just after a rising edge
`timescale 1ns/10ps
module tcoi_host_model
(
	input wire logic i_mclk,
	input wire logic i_ready,
	output tcoi_pkg::tcoi_word_t o_tx,
	output logic o_valid
);
	tcoi_pkg::tcoi_word_t q[$];
	initial
	begin
		o_tx = '0;
		o_valid = 1'b0;
	end
	// whole words only, so the prefix sits alone on a word boundary
	task automatic run(output bit ok);
		int n;
		ok = 1'b1;
		while (q.size() > 0)
		begin
			o_tx <= q.pop_front();
			o_valid <= 1'b1;
			n = 0;
			do
			begin
				@(posedge i_mclk);
				n++;
			end
			while (i_ready !== 1'b1 && n < 200);
			ok &= n < 200;
		end
		o_valid <= 1'b0;
		o_tx <= ~o_tx; // released bus must not look like a word
	endtask : run
endmodule : tcoi_host_model

// [tb/tb_tcoi_inserter.sv]
// bench for the inserter: register access, checksum and pass-through packets
// assumes the host model file and the monitor are compiled before this file
`timescale 1ns/10ps
bind tcoi_inserter tcoi_monitor tcoi_monitor_inst (.i_mclk(i_mclk), .i_rst_n(i_rst_n),
	.i_avs_address(i_avs_address), .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
	.i_avs_writedata(i_avs_writedata), .i_avs_byteenable(i_avs_byteenable), .o_avs_readdata(o_avs_readdata),
	.o_avs_waitrequest(o_avs_waitrequest), .i_tx(i_tx), .i_tx_valid(i_tx_valid), .o_tx_ready(o_tx_ready),
	.o_mac(o_mac), .o_mac_valid(o_mac_valid), .i_mac_ready(i_mac_ready));
module tb_tcoi_inserter;
	logic i_mclk = 1'b0;
	logic i_rst_n = 1'b0;
	logic [3:0] i_avs_address = 4'h0;
	logic i_avs_read = 1'b0;
	logic i_avs_write = 1'b0;
	logic [31:0] i_avs_writedata = 32'h0000_0000;
	logic [3:0] i_avs_byteenable = 4'h1;
	logic [31:0] o_avs_readdata;
	logic o_avs_waitrequest;
	tcoi_pkg::tcoi_word_t i_tx;
	logic i_tx_valid;
	logic o_tx_ready;
	tcoi_pkg::tcoi_word_t o_mac;
	logic o_mac_valid;
	logic i_mac_ready = 1'b0;
	logic [7:0] fb [68];
	int errors = 0;
	int check_count = 0;
	always #2.5 i_mclk = ~i_mclk;
	tcoi_inserter tcoi_inserter_inst (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_avs_address(i_avs_address),
		.i_avs_read(i_avs_read), .i_avs_write(i_avs_write), .i_avs_writedata(i_avs_writedata),
		.i_avs_byteenable(i_avs_byteenable), .o_avs_readdata(o_avs_readdata),
		.o_avs_waitrequest(o_avs_waitrequest), .i_tx(i_tx), .i_tx_valid(i_tx_valid),
		.o_tx_ready(o_tx_ready), .o_mac(o_mac), .o_mac_valid(o_mac_valid), .i_mac_ready(i_mac_ready));
	tcoi_host_model tcoi_host_model_inst (.i_mclk(i_mclk), .i_ready(o_tx_ready), .o_tx(i_tx),
		.o_valid(i_tx_valid));
	task automatic end_sim;
		$display("checks %0d errors %0d", check_count, errors);
		if (errors == 0 && check_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : end_sim
	task automatic timeout;
		errors++;
		$display("[FAIL] wait limit expected 0 seen 1");
		end_sim();
	endtask : timeout
	task automatic check(string name, logic [34:0] seen, logic [34:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			errors++;
			$display("[FAIL] %s expected %h seen %h", name, exp, seen);
		end
	endtask : check
	task automatic bus(logic wr, logic [3:0] a, logic [31:0] d, output logic [31:0] q);
		int n;
		@(posedge i_mclk);
		i_avs_address <= a;
		i_avs_writedata <= d;
		i_avs_write <= wr;
		i_avs_read <= !wr;
		n = 0;
		do
		begin
			@(posedge i_mclk);
			n++;
		end
		while (o_avs_waitrequest !== 1'b0 && n < 50);
		q = o_avs_readdata;
		i_avs_read <= 1'b0;
		i_avs_write <= 1'b0;
		if (n >= 50)
			timeout();
	endtask : bus
	task automatic wr(logic [3:0] a, logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask : wr
	task automatic rd(string name, logic [3:0] a, logic [31:0] exp);
		logic [31:0] q;
		bus(1'b0, a, 32'h0000_0000, q);
		check(name, q, exp);
	endtask : rd
	// builds, sends and collects one packet; mac ready stalls every other cycle
	task automatic pkt(string name, logic [31:0] ca, logic pre_on, logic cs, int nb, int st, int ins,
		output logic [15:0] c);
		logic [7:0] eb [68];
		logic [31:0] sum;
		tcoi_pkg::tcoi_word_t w;
		tcoi_pkg::tcoi_word_t ex[$];
		bit ok;
		int n;
		int k;
		for (int i = nb; i < 68; i++) fb[i] = 8'h00;
		sum = 32'h0000_0000;
		for (int i = st; i < nb; i += 2) sum += {(i + 1 < nb) ? fb[i + 1] : 8'h00, fb[i]};
		sum = sum[15:0] + sum[31:16];
		sum = sum[15:0] + sum[31:16];
		c = ~sum[15:0];
		eb = fb;
		if (cs)
		begin
			eb[ins] = ((ins - st) % 2 == 0) ? c[7:0] : c[15:8];
			eb[ins + 1] = ((ins - st) % 2 == 0) ? c[15:8] : c[7:0];
		end
		w = {ca, 3'b000};
		tcoi_host_model_inst.q.push_back(w);
		ex.push_back(w);
		w.data = (32'(pre_on) << tcoi_pkg::CMDB_CSUM_REQ_BIT) | 32'(nb + (pre_on ? 4 : 0));
		tcoi_host_model_inst.q.push_back(w);
		ex.push_back(w);
		w.data = {4'h0, ins[11:0], 4'h0, st[11:0]};
		if (pre_on)
			tcoi_host_model_inst.q.push_back(w);
		if (pre_on && !cs)
			ex.push_back(w);
		for (int i = 0; i < nb; i += 4)
		begin
			w.last = i + 4 >= nb;
			w.bytes = w.last ? nb[1:0] : 2'b00;
			w.data = {fb[i + 3], fb[i + 2], fb[i + 1], fb[i]};
			tcoi_host_model_inst.q.push_back(w);
			w.data = {eb[i + 3], eb[i + 2], eb[i + 1], eb[i]};
			ex.push_back(w);
		end
		tcoi_host_model_inst.run(ok);
		if (!ok)
			timeout();
		n = 0;
		k = 0;
		while (k < ex.size() && n < 3000)
		begin
			@(posedge i_mclk);
			n++;
			if (o_mac_valid === 1'b1 && i_mac_ready === 1'b1)
			begin
				check(name, o_mac, ex[k]);
				k++;
			end
			i_mac_ready <= n[0];
		end
		i_mac_ready <= 1'b0;
		while (o_tx_ready !== 1'b1 && n < 3000)
		begin
			@(posedge i_mclk);
			n++;
		end
		if (n >= 3000)
			timeout();
		$display("test %s done", name);
	endtask : pkt
	task automatic t_regs;
		rd("ctrl", tcoi_pkg::REG_CTRL_OFS, tcoi_pkg::REG_RESET);
		rd("stat", tcoi_pkg::REG_STAT_OFS, tcoi_pkg::REG_RESET);
		rd("count", tcoi_pkg::REG_COUNT_OFS, tcoi_pkg::REG_RESET);
		rd("csum", tcoi_pkg::REG_CSUM_OFS, tcoi_pkg::REG_RESET);
		wr(tcoi_pkg::REG_COUNT_OFS, 32'h0000_00FF);
		rd("count ro", tcoi_pkg::REG_COUNT_OFS, 32'h0000_0000);
		wr(4'h1, 32'h0000_0003);
		rd("unmapped", 4'h1, 32'h0000_0000);
		wr(tcoi_pkg::REG_CTRL_OFS, 32'h0000_0003);
		rd("ctrl rw", tcoi_pkg::REG_CTRL_OFS, 32'h0000_0003);
		wr(tcoi_pkg::REG_CTRL_OFS, 32'h0000_0001);
		$display("test regs done");
	endtask : t_regs
	task automatic t_csum_odd;
		logic [15:0] c;
		for (int i = 0; i < 23; i++) fb[i] = 8'(i * 37 + 5);
		pkt("csum odd", 32'h0000_2000, 1'b1, 1'b1, 23, 14, 17, c);
		rd("count one", tcoi_pkg::REG_COUNT_OFS, 32'h0000_0001);
		rd("csum reg", tcoi_pkg::REG_CSUM_OFS, {16'h0000, c});
	endtask : t_csum_odd
	task automatic t_csum_zero;
		logic [15:0] c;
		for (int i = 0; i < 22; i++) fb[i] = (i == 14 || i == 15) ? 8'hFF : 8'h00;
		// offsets kept clear of header and tail; no udp over ipv6 here
		pkt("csum zero", 32'h0000_2000, 1'b1, 1'b1, 22, 14, 14, c);
		rd("csum zero reg", tcoi_pkg::REG_CSUM_OFS, 32'h0000_0000);
	endtask : t_csum_zero
	task automatic t_plain;
		logic [15:0] c;
		for (int i = 0; i < 21; i++) fb[i] = 8'(i * 11 + 1);
		pkt("no request", 32'h0000_2000, 1'b0, 1'b0, 21, 14, 16, c);
		wr(tcoi_pkg::REG_CTRL_OFS, 32'h0000_0000);
		pkt("disabled", 32'h0000_2000, 1'b1, 1'b0, 21, 14, 16, c);
		wr(tcoi_pkg::REG_CTRL_OFS, 32'h0000_0001);
		pkt("not first", 32'h0000_0000, 1'b1, 1'b0, 21, 14, 16, c);
		rd("count kept", tcoi_pkg::REG_COUNT_OFS, 32'h0000_0002);
	endtask : t_plain
	// frame two words past the buffer: dropped whole, sticky overflow, write-one clear
	task automatic t_overflow;
		tcoi_pkg::tcoi_word_t w;
		bit ok;
		int seen;
		w = '0;
		w.data = 32'h0000_2000;
		tcoi_host_model_inst.q.push_back(w);
		w.data = 32'h0000_1040;
		tcoi_host_model_inst.q.push_back(w);
		for (int i = 0; i < 1040; i++)
		begin
			w.data = 32'(i);
			w.last = (i == 1039);
			tcoi_host_model_inst.q.push_back(w);
		end
		tcoi_host_model_inst.run(ok);
		if (!ok)
			timeout();
		seen = 0;
		repeat (20)
		begin
			@(posedge i_mclk);
			seen += int'(o_mac_valid === 1'b1);
		end
		check("ovf nothing sent", 35'(seen), 35'h0);
		rd("ovf stat", tcoi_pkg::REG_STAT_OFS, 32'h0000_0002);
		wr(tcoi_pkg::REG_STAT_OFS, 32'h0000_0002);
		rd("ovf cleared", tcoi_pkg::REG_STAT_OFS, 32'h0000_0000);
		$display("test overflow done");
	endtask : t_overflow
	initial
	begin
		repeat (20) @(posedge i_mclk);
		i_rst_n <= 1'b1;
		t_regs();
		t_csum_odd();
		t_csum_zero();
		t_plain();
		t_overflow();
		end_sim();
	end
endmodule : tb_tcoi_inserter
